// File: rtl/clkgen_pkg.sv
package clkgen_pkg;
  // core clock and oscillator rates
  localparam int CLK_HZ = 200_000_000;
  localparam int SLOW_HZ = 32768;
  localparam int FAST_HZ = 8_389_000;
  localparam int SLOW_PERIOD = CLK_HZ / SLOW_HZ;
  localparam int FAST_PERIOD = CLK_HZ / FAST_HZ;
  localparam int FAST_TARGET = FAST_HZ / SLOW_HZ;
  localparam int FAST_TOL = 2;
  // divider ratios
  localparam int LINK_DIV = 8;
  localparam int NVM_DIV = 8;
  localparam int ADC_DIV = 128;
  localparam int TIMEOUT_DIV = 256;
  // power-up reset time, rounded up to slow ticks
  localparam int POR_TIME_US = 4000;
  localparam int POR_TICKS = (POR_TIME_US * SLOW_HZ + 999_999) / 1_000_000;
  // link-low timeout, counted in slow/256 ticks
  localparam int LINK_LOW_MS = 2000;
  localparam int TIMEOUT_HZ = SLOW_HZ / TIMEOUT_DIV;
  localparam int LINK_LOW_TICKS = LINK_LOW_MS * TIMEOUT_HZ / 1000;
  // converter
  localparam int CONVERSION_START_BIT_SAMPLES = 1024;
  localparam int ADC_STEP = 32;
  localparam logic [15:0] ADC_POS_FULL = 16'h7fff;
  localparam logic [15:0] ADC_NEG_FULL = 16'h8000;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_TRIM = 8'h0c;
  // field positions
  localparam int CTRL_CONVERSION_START_BIT = 0;
  localparam int CTRL_LINK_EN = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_VALID = 1;
  localparam int ST_POR = 2;
  localparam int ST_TIMEOUT = 3;
  // slow trim location in nonvolatile page 0
  localparam logic [8:0] SLOW_TRIM_ADDR = 9'h03e;
  localparam logic [7:0] SLOW_TRIM_RST = 8'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : clkgen_pkg

// File: rtl/tick_div.sv
`timescale 1ns/1ps
// counts step pulses and emits one tick every period steps while enabled
module tick_div #(
  parameter int W = 8
) (
  input wire logic aclk, // core clock
  input wire logic aresetn, // sync reset, active low
  input wire logic en, // divider runs while high
  input wire logic step, // source pulse
  input wire logic [W-1:0] period, // steps per tick
  output logic tick // one-cycle output pulse
);
  logic [W-1:0] cnt_q;

  if (W < 2) begin : g_chk
    $error("tick_div needs W of at least 2");
  end

  // dropping en clears the count, so a gated divider restarts in phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!en) begin
        cnt_q <= '0;
      end else if (step) begin
        if (cnt_q >= period - 1'b1) begin
          cnt_q <= '0;
          tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule : tick_div

// File: rtl/adc_accum.sv
`timescale 1ns/1ps
// delta-sigma decimator: saturating two's-complement accumulator
module adc_accum
  import clkgen_pkg::*;
#(
  parameter int SAMPLES = CONVERSION_START_BIT_SAMPLES,
  parameter int STEP = ADC_STEP
) (
  input wire logic aclk, // core clock
  input wire logic aresetn, // sync reset, active low
  input wire logic clr, // restart a conversion
  input wire logic step, // modulator sample strobe
  input wire logic mod_bit, // modulator bit
  output logic [15:0] result, // signed result
  output logic done // one-cycle end pulse
);
  import clkgen_pkg::*;
  logic [15:0] n_q;
  logic [16:0] sum;
  logic [15:0] sat;

  if (SAMPLES < 2 || SAMPLES > 65535 || STEP < 1 || STEP > 16384) begin : g_chk
    $error("adc_accum parameters out of range");
  end

  // the extra sum bit exposes overflow, which pins the code to a full-scale end
  assign sum = {result[15], result} + (mod_bit ? 17'(STEP) : -17'(STEP));
  assign sat = (sum[16] == sum[15]) ? sum[15:0] :
               (sum[16] ? ADC_NEG_FULL : ADC_POS_FULL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 16'h0000;
      n_q <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (clr) begin
        result <= 16'h0000;
        n_q <= 16'h0000;
      end else if (step) begin
        result <= sat;
        n_q <= n_q + 16'h0001;
        done <= (n_q == 16'(SAMPLES - 1));
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_no_rollover: assert property ($past(result) == ADC_POS_FULL && !$past(clr)
    |-> result != ADC_NEG_FULL) else $error("result wrapped");
endmodule : adc_accum

// File: rtl/clock_gen_and_temp_adc_ctrl.sv
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// - conversion result is presented as a 16-bit word
// - writing one to the start bit begins conversion; hardware clears it at end
// - start sets busy and clears the result-valid flag
// - end of conversion clears start bit and busy, sets result-valid
// - writing zero to the start bit aborts a running conversion
// - result is two's complement, positive full scale equals reference
// - result saturates, never wrapping from positive to negative full scale
// - slow oscillator runs continuously except in shutdown
// - fast oscillator enabled only while some consumer needs it
// - clocks of unused modules and interfaces are gated off
// - after reset, slow trim is read from page 0 into trim register
// - slow-clocked trim loop keeps adjusting fast oscillator while enabled
// - power-up reset period of 4 ms timed on slow ticks
// - link held low 2 s detected by slow/256 timeout counter
// - link logic and unmapped register access clocked at fast/8
// - nonvolatile reads and programming clocked at fast/8
// - converter clocked at fast/128 while a conversion runs
module clock_gen_and_temp_adc_ctrl
  import clkgen_pkg::*;
#(
  parameter int SLOW_PERIOD_CYC = SLOW_PERIOD,
  parameter int FAST_PERIOD_CYC = FAST_PERIOD
) (
  input wire logic aclk, // 200 MHz core clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic shutdown, // device in shutdown
  input wire logic link_in, // single-wire link level
  input wire logic adc_mod_bit, // modulator bitstream
  input wire logic nvm_busy, // nonvolatile access under way
  input wire logic nvm_rd_valid, // read data valid
  input wire logic [7:0] nvm_rd_data, // read data
  output logic nvm_rd_req, // trim read request
  output logic [8:0] nvm_rd_addr, // trim read address
  output logic slow_osc_tick, // slow oscillator pulse
  output logic fast_osc_tick, // fast oscillator pulse
  output logic fast_osc_en, // fast oscillator enable
  output logic link_clk_en, // fast/8 link clock pulse
  output logic nvm_clk_en, // fast/8 memory clock pulse
  output logic adc_clk_en, // fast/128 converter pulse
  output logic [7:0] slow_trim, // slow oscillator trim
  output logic [7:0] fast_trim, // fast oscillator trim
  output logic por_done, // power-up period over
  output logic link_low_timeout // link low for 2 s
);
  import clkgen_pkg::*;

  typedef enum logic [1:0] {TL_IDLE, TL_REQ, TL_DONE} trim_st_t;

  if (SLOW_PERIOD_CYC < 200 || SLOW_PERIOD_CYC > 16000 ||
      FAST_PERIOD_CYC < 2 || FAST_PERIOD_CYC > 255) begin : g_chk
    $error("oscillator periods out of range");
  end

  logic aw_have, w_have, wr_fire, rd_hit, wr_hit;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic wr_ctrl, start_go, abort_go, conversion_start_bit_done;
  logic busy_q, valid_q, link_en_q, unmap_q;
  logic fast_need, slow256_tick;
  logic [13:0] slow_per;
  logic [15:0] adc_result;
  logic [15:0] por_cnt_q;
  logic [8:0] low_cnt_q;
  logic [9:0] fcnt_q;
  trim_st_t tl_q;

  // ---- AXI4-Lite slave
  assign aw_have = !s_axi_awready;
  assign w_have = !s_axi_wready;
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;
  assign wr_hit = (awaddr_q == OFF_CTRL) || (awaddr_q == OFF_STATUS) ||
                  (awaddr_q == OFF_RESULT) || (awaddr_q == OFF_TRIM);
  assign rd_hit = (araddr_q == OFF_CTRL) || (araddr_q == OFF_STATUS) ||
                  (araddr_q == OFF_RESULT) || (araddr_q == OFF_TRIM);
  assign wr_ctrl = wr_fire && (awaddr_q == OFF_CTRL) && wstrb_q[0];

  // address and data are latched independently; the answer waits for both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read mux; the result goes out raw, temperature scaling is host work
  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr_q)
      OFF_CTRL: begin
        rd_word[CTRL_CONVERSION_START_BIT] = busy_q;
        rd_word[CTRL_LINK_EN] = link_en_q;
      end
      OFF_STATUS: begin
        rd_word[ST_BUSY] = busy_q;
        rd_word[ST_VALID] = valid_q;
        rd_word[ST_POR] = por_done;
        rd_word[ST_TIMEOUT] = link_low_timeout;
      end
      OFF_RESULT: rd_word[15:0] = adc_result;
      OFF_TRIM: rd_word[15:0] = {fast_trim, slow_trim};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // one read at a time: arready drops until the data are taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      araddr_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      araddr_q <= s_axi_araddr;
      s_axi_arready <= 1'b0;
    end else if (!s_axi_arready && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---- conversion control
  assign start_go = wr_ctrl && wdata_q[CTRL_CONVERSION_START_BIT] && !busy_q;
  assign abort_go = wr_ctrl && !wdata_q[CTRL_CONVERSION_START_BIT] && busy_q;

  // start bit and busy share one flop; a write of one while busy is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      valid_q <= 1'b0;
      link_en_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        link_en_q <= wdata_q[CTRL_LINK_EN];
      end
      if (start_go) begin
        busy_q <= 1'b1;
        valid_q <= 1'b0;
      end else if (abort_go) begin
        busy_q <= 1'b0;
      end else if (conversion_start_bit_done && busy_q) begin
        busy_q <= 1'b0;
        valid_q <= 1'b1;
      end
    end
  end

  adc_accum u_accum (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(start_go),
    .step(adc_clk_en && busy_q),
    .mod_bit(adc_mod_bit),
    .result(adc_result),
    .done(conversion_start_bit_done)
  );

  // ---- oscillators and dividers
  assign slow_per = 14'(SLOW_PERIOD_CYC) + {{6{slow_trim[7]}}, slow_trim};
  // an unmapped access holds the fast/8 request until one pulse is given
  assign fast_need = link_en_q || unmap_q || nvm_busy || nvm_rd_req || busy_q;

  tick_div #(.W(14)) u_slow (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(!shutdown),
    .step(1'b1),
    .period(slow_per),
    .tick(slow_osc_tick)
  );

  tick_div #(.W(8)) u_fast (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(fast_osc_en),
    .step(1'b1),
    .period(fast_trim),
    .tick(fast_osc_tick)
  );

  tick_div #(.W(4)) u_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(fast_osc_en && (link_en_q || unmap_q)),
    .step(fast_osc_tick),
    .period(4'(LINK_DIV)),
    .tick(link_clk_en)
  );

  tick_div #(.W(4)) u_nvm (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(fast_osc_en && (nvm_busy || nvm_rd_req)),
    .step(fast_osc_tick),
    .period(4'(NVM_DIV)),
    .tick(nvm_clk_en)
  );

  tick_div #(.W(8)) u_adc (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(fast_osc_en && busy_q),
    .step(fast_osc_tick),
    .period(8'(ADC_DIV - 1) + 8'h01),
    .tick(adc_clk_en)
  );

  tick_div #(.W(9)) u_slow256 (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(!shutdown),
    .step(slow_osc_tick),
    .period(9'(TIMEOUT_DIV)),
    .tick(slow256_tick)
  );

  // fast enable follows demand one cycle late; unmapped flag: set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_en <= 1'b0;
      unmap_q <= 1'b0;
    end else begin
      fast_osc_en <= fast_need;
      unmap_q <= (wr_fire && !wr_hit) || (s_axi_rvalid && s_axi_rready && !rd_hit) ||
                 (unmap_q && !link_clk_en);
    end
  end

  // fast trim: count fast pulses per slow period and nudge the period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_trim <= 8'(FAST_PERIOD_CYC);
      fcnt_q <= 10'h000;
    end else if (!fast_osc_en) begin
      fcnt_q <= 10'h000;
    end else if (slow_osc_tick) begin
      fcnt_q <= 10'h000;
      if (fcnt_q < 10'(FAST_TARGET - FAST_TOL) && fast_trim > 8'h02) begin
        fast_trim <= fast_trim - 8'h01;
      end else if (fcnt_q > 10'(FAST_TARGET + FAST_TOL) && fast_trim != 8'hff) begin
        fast_trim <= fast_trim + 8'h01;
      end
    end else if (fast_osc_tick && fcnt_q != 10'h3ff) begin
      fcnt_q <= fcnt_q + 10'h001;
    end
  end

  // ---- slow trim load from page 0 right after reset
  assign nvm_rd_addr = SLOW_TRIM_ADDR;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tl_q <= TL_IDLE;
      nvm_rd_req <= 1'b0;
      slow_trim <= SLOW_TRIM_RST;
    end else begin
      unique case (tl_q)
        TL_IDLE: begin
          tl_q <= TL_REQ;
          nvm_rd_req <= 1'b1;
        end
        TL_REQ: if (nvm_rd_valid) begin
          slow_trim <= nvm_rd_data;
          nvm_rd_req <= 1'b0;
          tl_q <= TL_DONE;
        end
        TL_DONE: tl_q <= TL_DONE;
      endcase
    end
  end

  // ---- power-up timer and link-low timeout, both on slow-derived pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_q <= 16'h0000;
      por_done <= 1'b0;
      low_cnt_q <= 9'h000;
      link_low_timeout <= 1'b0;
    end else begin
      if (slow_osc_tick && !por_done) begin
        por_cnt_q <= por_cnt_q + 16'h0001;
        por_done <= (por_cnt_q == 16'(POR_TICKS - 1));
      end
      // the timeout stays up while the line is low and drops once it is released
      if (link_in) begin
        low_cnt_q <= 9'h000;
        link_low_timeout <= 1'b0;
      end else if (slow256_tick && !link_low_timeout) begin
        low_cnt_q <= low_cnt_q + 9'h001;
        link_low_timeout <= (low_cnt_q == 9'(LINK_LOW_TICKS - 1));
      end
    end
  end

  // ---- assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_started;
    start_go ##1 (busy_q && !valid_q);
  endsequence

  a_start_flags: assert property (start_go |-> s_started)
    else $error("start did not set busy");
  a_conversion_start_bit_reads_one: assert property ($rose(s_axi_rvalid) && araddr_q == OFF_CTRL
    |-> s_axi_rdata[CTRL_CONVERSION_START_BIT] == $past(busy_q)) else $error("start bit read wrong");
  a_done_flags: assert property (conversion_start_bit_done && busy_q && !abort_go && !start_go
    |=> !busy_q && valid_q) else $error("end flags wrong");
  a_abort_clear: assert property (abort_go |=> !busy_q && !valid_q [*2])
    else $error("abort did not stop");
  a_result_hold: assert property (valid_q && !start_go |=> $stable(adc_result) && valid_q)
    else $error("result changed while valid");
  a_fast_gated: assert property (!fast_need |=> !fast_osc_en ##1 !fast_osc_tick)
    else $error("fast oscillator ran unneeded");
  a_adc_gated: assert property (adc_clk_en |-> $past(busy_q) && fast_osc_en)
    else $error("converter clock while idle");
  a_link_gated: assert property (link_clk_en |-> $past(link_en_q || unmap_q))
    else $error("link clock while unused");
  a_trim_load: assert property (tl_q == TL_REQ && nvm_rd_valid
    |=> slow_trim == $past(nvm_rd_data) && !nvm_rd_req) else $error("trim not loaded");
  a_por_count: assert property ($rose(por_done) |-> por_cnt_q == 16'(POR_TICKS))
    else $error("power-up period wrong");
  a_timeout_count: assert property ($rose(link_low_timeout)
    |-> low_cnt_q == 9'(LINK_LOW_TICKS) && !link_in) else $error("timeout count wrong");
endmodule : clock_gen_and_temp_adc_ctrl

// File: tb/gauge_side_model.sv
`timescale 1ns/1ps
// stands in for the trim memory, the link line and the modulator
module gauge_side_model #(
  parameter logic [7:0] TRIM_VAL = 8'h05,
  parameter int BUSY_CYC = 2000
) (
  input wire logic aclk, // core clock
  input wire logic aresetn, // sync reset, active low
  input wire logic nvm_rd_req, // trim fetch request
  input wire logic adc_clk_en, // converter sample pulse
  input wire logic link_hold_low, // bench pulls the line low
  output logic nvm_busy, // memory access under way
  output logic nvm_rd_valid, // one-cycle answer
  output logic [7:0] nvm_rd_data, // answer data
  output logic link_in, // line level
  output logic adc_mod_bit // modulator bit
);
  logic [11:0] cnt_q;
  logic done_q;
  logic [7:0] junk_q;
  // a slow memory: busy for a long while before it answers, once per reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 12'h000;
      done_q <= 1'b0;
      junk_q <= 8'h5a;
      adc_mod_bit <= 1'b1;
    end else begin
      junk_q <= ~junk_q;
      if (nvm_rd_req && !done_q) cnt_q <= cnt_q + 12'h001;
      if (nvm_rd_valid) done_q <= 1'b1;
      if (adc_clk_en) adc_mod_bit <= ~adc_mod_bit;
    end
  end
  // data bus shows a changing pattern outside the answer so stale values never match
  assign nvm_rd_valid = nvm_rd_req && !done_q && (cnt_q == 12'(BUSY_CYC));
  assign nvm_busy = nvm_rd_req && !done_q && !nvm_rd_valid;
  assign nvm_rd_data = nvm_rd_valid ? TRIM_VAL : junk_q;
  assign link_in = ~link_hold_low; // pull-up keeps the idle line high
endmodule : gauge_side_model

// File: tb/clock_gen_and_temp_adc_ctrl_test.sv
`timescale 1ns/1ps
module clock_gen_and_temp_adc_ctrl_test;
  import clkgen_pkg::*;
  localparam int SLOW_CYC = 200;
  localparam logic [7:0] TRIM_VAL = 8'h05;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, data;
  logic shutdown = 1'b0;
  logic link_hold_low = 1'b0;
  logic link_in, adc_mod_bit, nvm_busy, nvm_rd_valid, nvm_rd_req;
  logic [7:0] nvm_rd_data, slow_trim, fast_trim;
  logic [8:0] nvm_rd_addr;
  logic slow_osc_tick, fast_osc_tick, fast_osc_en, link_clk_en, nvm_clk_en, adc_clk_en;
  logic por_done, link_low_timeout;
  int mismatches = 0;
  int check_count = 0;
  int n_slow = 0;
  int n_adc = 0;
  int n_link = 0;
  int n_fast = 0;
  int k;

  always #2.5 aclk = ~aclk;

  // pulse counters let a scenario compare activity over a window
  always @(posedge aclk) begin
    if (slow_osc_tick === 1'b1) n_slow <= n_slow + 1;
    if (adc_clk_en === 1'b1) n_adc <= n_adc + 1;
    if (link_clk_en === 1'b1) n_link <= n_link + 1;
    if (fast_osc_tick === 1'b1) n_fast <= n_fast + 1;
  end

  clock_gen_and_temp_adc_ctrl #(.SLOW_PERIOD_CYC(SLOW_CYC)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shutdown, .link_in, .adc_mod_bit,
    .nvm_busy, .nvm_rd_valid, .nvm_rd_data, .nvm_rd_req, .nvm_rd_addr, .slow_osc_tick,
    .fast_osc_tick, .fast_osc_en, .link_clk_en, .nvm_clk_en, .adc_clk_en, .slow_trim,
    .fast_trim, .por_done, .link_low_timeout);

  gauge_side_model #(.TRIM_VAL(TRIM_VAL)) far_side (
    .aclk, .aresetn, .nvm_rd_req, .adc_clk_en, .link_hold_low, .nvm_busy,
    .nvm_rd_valid, .nvm_rd_data, .link_in, .adc_mod_bit);

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic give_up;
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    complete_run();
  endtask : give_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // waits a bounded number of edges for a level on a design output
  task automatic wait_val(ref logic s, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && s !== v; n++) @(posedge aclk);
    if (n == lim) give_up();
  endtask : wait_val

  // both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 64) give_up();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 64) give_up();
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // the watchdog ends a hung run through the same closing report
  initial begin
    repeat (100000) @(posedge aclk);
    give_up();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // trim fetch: memory clock and fast oscillator run only while the fetch is open
    wait_val(nvm_clk_en, 1'b1, 4000);
    chk(32'(fast_osc_en), 32'h1);
    chk(32'(nvm_rd_addr), 32'(SLOW_TRIM_ADDR));
    wait_val(nvm_rd_req, 1'b0, 4000);
    repeat (3) @(posedge aclk);
    chk(32'(fast_osc_en), 32'h0);
    chk(32'(slow_trim), 32'(TRIM_VAL));
    // the short slow period sees too few fast pulses, so the loop must shorten the period
    chk(32'(fast_trim < 8'(FAST_PERIOD)), 32'h1);
    rd(OFF_TRIM);
    chk(32'(data[7:0]), 32'(TRIM_VAL));
    // idle: gated clocks and the fast oscillator stay quiet
    k = n_adc + n_link + n_fast;
    repeat (2000) @(posedge aclk);
    chk(n_adc + n_link + n_fast, k);
    rd(OFF_STATUS);
    chk(32'(data[1:0]), 32'h0);
    // start, repeated start, then abort
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS);
    chk(32'(data[1:0]), 32'h1);
    rd(OFF_CTRL);
    chk(32'(data[0]), 32'h1);
    wait_val(adc_clk_en, 1'b1, 40000);
    chk(32'(fast_osc_en), 32'h1);
    rd(OFF_RESULT);
    chk(32'(data[31:16]), 32'h0);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS);
    chk(32'(data[1:0]), 32'h1);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STATUS);
    chk(32'(data[1:0]), 32'h0);
    rd(OFF_CTRL);
    chk(32'(data[0]), 32'h0);
    k = n_adc;
    repeat (4000) @(posedge aclk);
    chk(n_adc, k);
    // link enable brings up the fast/8 link clock
    wr(OFF_CTRL, 32'h2);
    rd(OFF_CTRL);
    chk(32'(data[1:0]), 32'h2);
    wait_val(link_clk_en, 1'b1, 4000);
    chk(32'(fast_osc_en), 32'h1);
    wr(OFF_CTRL, 32'h0);
    // unmapped place: error response, no data, and a fast/8 pulse on demand alone
    rd(8'h10);
    chk(32'(resp), 32'(RESP_SLVERR));
    chk(data, 32'h0);
    wait_val(link_clk_en, 1'b1, 4000);
    wr(8'h10, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    // shutdown halts the slow oscillator, release restarts it
    shutdown <= 1'b1;
    repeat (2) @(posedge aclk);
    k = n_slow;
    repeat (1000) @(posedge aclk);
    chk(n_slow, k);
    shutdown <= 1'b0;
    wait_val(slow_osc_tick, 1'b1, 600);
    // power-up period ends after 132 slow ticks
    wait_val(por_done, 1'b1, 40000);
    chk(32'(n_slow >= POR_TICKS && n_slow <= POR_TICKS + 1), 32'h1);
    rd(OFF_STATUS);
    chk(32'(data[2]), 32'h1);
    // a short low on the line is no timeout
    link_hold_low <= 1'b1;
    repeat (2000) @(posedge aclk);
    chk(32'(link_low_timeout), 32'h0);
    link_hold_low <= 1'b0;
    complete_run();
  end
endmodule : clock_gen_and_temp_adc_ctrl_test
